// ### fabp_defines.vh
// Constants for the flash asynchronous bus port controller.
`ifndef FABP_DEFINES_VH
`define FABP_DEFINES_VH
`define FABP_CLK_MHZ         125
`define FABP_RECOVERY_US     10
`define FABP_RECOVERY_CYC    (`FABP_RECOVERY_US * `FABP_CLK_MHZ)
`define FABP_ADDR_CYCLES     4
`define FABP_OP_CMD          2'h0
`define FABP_OP_ADDR         2'h1
`define FABP_OP_WDATA        2'h2
`define FABP_OP_RDATA        2'h3
`define FABP_STROBE_LOW_CYC  4'h4
`define FABP_STROBE_HIGH_CYC 4'h4
`define FABP_RD_SAMPLE_CYC   4'h4
`define FABP_RD_ACCESS_CYC   3
`endif

// ### fabp_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
module fabp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ### fabp_host.v
// Host controller that drives the flash asynchronous bus port pins.
//
// Summary of operation
// - Low lanes carry commands, addresses, data
// - High lanes carry data only, x16
// - Command: select, command latch, read high
// - Address: select, address latch, read high
// - Host sends four address cycles
// - Data in: latches low, one word per strobe
// - Data out: one word per read pulse
// - Hold select low during read busy
// - Wired ready/busy low means someone busy
// - No commands during 10 us recovery
// - Write strobe high, protect low at power
// - Protect high for program/erase commands
`include "fabp_defines.vh"

module fabp_host #(
  parameter WIDE          = 1,
  parameter RECOVERY_CYC  = `FABP_RECOVERY_CYC,
  parameter FIFO_DEPTH    = 4,
  parameter FIFO_AW       = 2
) (
  // Clock, enable and reset
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // Power transition indication
  input  wire        power_event,
  // Request port
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [1:0]  req_op,
  input  wire [15:0] req_data,
  input  wire        req_hold_select,
  input  wire        req_write_enable,
  // Read data stream
  output wire        rd_valid,
  input  wire        rd_ready,
  output wire [15:0] rd_data,
  // Status
  output reg         busy_r,
  output reg         device_ready_r,
  output reg  [1:0]  addr_count_r,
  // Flash pins
  output reg         chip_sel_n_r,
  output reg         command_latch_en,
  output reg         address_latch_en,
  output reg         write_n_r,
  output reg         read_n_r,
  output reg         wp_n_r,
  input  wire [7:0]  bus_low_lanes_i,
  output reg  [7:0]  bus_low_lanes_o,
  output reg         bus_low_lanes_oe_n,
  input  wire [7:0]  bus_high_lanes_i,
  output reg  [7:0]  bus_high_lanes_o,
  output reg         bus_high_lanes_oe_n,
  input  wire        ready_busy_od
);
  // ---------------------------------------------------------------
  // State encoding
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_SETUP  = 3'h1;
  localparam [2:0] ST_LOW    = 3'h2;
  localparam [2:0] ST_HIGH   = 3'h3;
  localparam [2:0] ST_PUSH   = 3'h4;
  localparam [2:0] ST_RECOV  = 3'h5;

  reg [2:0]  state_r;
  reg [1:0]  op_r;
  reg        hold_r;
  reg [31:0] recov_cnt_r;
  reg [3:0]  phase_cnt_r;
  reg [15:0] cap_r;
  reg        rb_s1_r;
  reg        rb_s2_r;
  wire       fifo_in_ready;
  wire       push_valid;

  // ---------------------------------------------------------------
  // Phase lengths
  // ---------------------------------------------------------------
  localparam [3:0] LOW_CYC    = `FABP_STROBE_LOW_CYC;
  localparam [3:0] HIGH_CYC   = `FABP_STROBE_HIGH_CYC;
  localparam [3:0] RD_LOW_CYC = `FABP_RD_SAMPLE_CYC;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // True for transfers that strobe the read line instead of the write line.
  function is_read_op;
    input [1:0] op;
    begin
      is_read_op = (op == `FABP_OP_RDATA);
    end
  endfunction

  // Latch enables are decoded as a pair so both can never be high at once.
  function [1:0] latch_decode;
    input [1:0] op;
    begin
      case (op)
        `FABP_OP_CMD:  latch_decode = 2'b10;
        `FABP_OP_ADDR: latch_decode = 2'b01;
        default:       latch_decode = 2'b00;
      endcase
    end
  endfunction

  // Each phase is counted in clock cycles.
  // A read keeps its strobe low long enough for the access delay to pass.
  function [3:0] phase_len;
    input [2:0] st;
    input [1:0] op;
    begin
      if (st != ST_LOW) begin
        phase_len = HIGH_CYC;
      end else if (is_read_op(op)) begin
        phase_len = RD_LOW_CYC;
      end else begin
        phase_len = LOW_CYC;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Request handshake and read data buffer
  // ---------------------------------------------------------------
  assign push_valid = (state_r == ST_PUSH);
  assign req_ready  = ce & (state_r == ST_IDLE) & device_ready_r;

  fabp_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_r),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // ---------------------------------------------------------------
  // Ready/busy synchroniser
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else if (ce) begin
      rb_s1_r <= ready_busy_od;
      rb_s2_r <= rb_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Every transfer walks a setup, a strobe low and a strobe high phase.
  // The device takes written bytes on the rising write strobe.
  // Read lanes are sampled at the end of the low phase, then the strobe rises.
  // A power transition restarts the recovery wait from any state.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r             <= ST_RECOV;
      op_r                <= 2'h0;
      hold_r              <= 1'b0;
      recov_cnt_r         <= 32'h00000000;
      phase_cnt_r         <= 4'h0;
      cap_r               <= 16'h0000;
      busy_r              <= 1'b1;
      device_ready_r      <= 1'b0;
      addr_count_r        <= 2'h0;
      chip_sel_n_r        <= 1'b1;
      command_latch_en    <= 1'b0;
      address_latch_en    <= 1'b0;
      write_n_r           <= 1'b1;
      read_n_r            <= 1'b1;
      wp_n_r              <= 1'b0;
      bus_low_lanes_o     <= 8'h00;
      bus_low_lanes_oe_n  <= 1'b1;
      bus_high_lanes_o    <= 8'h00;
      bus_high_lanes_oe_n <= 1'b1;
    end else if (ce) begin
      // A low on the shared line means at least one device is busy.
      busy_r <= ~rb_s2_r;
      if (power_event) begin
        // Recovery after a power transition: strobe high, protect low.
        state_r            <= ST_RECOV;
        recov_cnt_r        <= 32'h00000000;
        device_ready_r     <= 1'b0;
        write_n_r          <= 1'b1;
        wp_n_r             <= 1'b0;
        chip_sel_n_r       <= 1'b1;
        command_latch_en   <= 1'b0;
        address_latch_en   <= 1'b0;
        read_n_r           <= 1'b1;
        bus_low_lanes_oe_n <= 1'b1;
        bus_high_lanes_oe_n <= 1'b1;
      end else begin
        case (state_r)
          ST_RECOV: begin
            if (recov_cnt_r >= RECOVERY_CYC - 1) begin
              state_r        <= ST_IDLE;
              device_ready_r <= 1'b1;
            end else begin
              recov_cnt_r <= recov_cnt_r + 32'h00000001;
            end
          end
          ST_IDLE: begin
            // Select stays low between requests when asked, covering read busy time.
            if (!hold_r) begin
              chip_sel_n_r <= 1'b1;
            end
            if (req_valid & device_ready_r) begin
              op_r        <= req_op;
              hold_r      <= req_hold_select;
              wp_n_r      <= req_write_enable;
              chip_sel_n_r <= 1'b0;
              read_n_r    <= 1'b1;
              phase_cnt_r <= 4'h0;
              {command_latch_en, address_latch_en} <= latch_decode(req_op);
              if (req_op == `FABP_OP_CMD) begin
                addr_count_r <= 2'h0;
              end
              if (!is_read_op(req_op)) begin
                bus_low_lanes_o    <= req_data[7:0];
                bus_low_lanes_oe_n <= 1'b0;
                // Commands and addresses use only the low lanes.
                bus_high_lanes_o    <= req_data[15:8];
                bus_high_lanes_oe_n <= ~((WIDE != 0) & (req_op == `FABP_OP_WDATA));
              end else begin
                bus_low_lanes_oe_n  <= 1'b1;
                bus_high_lanes_oe_n <= 1'b1;
              end
              state_r <= ST_SETUP;
            end
          end
          ST_SETUP: begin
            if (is_read_op(op_r)) begin
              if (fifo_in_ready) begin
                read_n_r <= 1'b0;
                state_r  <= ST_LOW;
              end
            end else begin
              write_n_r <= 1'b0;
              state_r   <= ST_LOW;
            end
          end
          ST_LOW: begin
            phase_cnt_r <= phase_cnt_r + 4'h1;
            if (phase_cnt_r == phase_len(state_r, op_r) - 4'h1) begin
              phase_cnt_r <= 4'h0;
              if (is_read_op(op_r)) begin
                // Sample after the access delay, then release the strobe.
                cap_r    <= {(WIDE != 0) ? bus_high_lanes_i : 8'h00, bus_low_lanes_i};
                read_n_r <= 1'b1;
              end else begin
                // Rising write strobe latches the byte or word.
                write_n_r <= 1'b1;
                if (op_r == `FABP_OP_ADDR) begin
                  addr_count_r <= addr_count_r + 2'h1;
                end
              end
              state_r <= ST_HIGH;
            end
          end
          ST_HIGH: begin
            phase_cnt_r <= phase_cnt_r + 4'h1;
            if (phase_cnt_r == phase_len(state_r, op_r) - 4'h1) begin
              phase_cnt_r        <= 4'h0;
              command_latch_en   <= 1'b0;
              address_latch_en   <= 1'b0;
              bus_low_lanes_oe_n <= 1'b1;
              bus_high_lanes_oe_n <= 1'b1;
              state_r <= is_read_op(op_r) ? ST_PUSH : ST_IDLE;
            end
          end
          ST_PUSH: begin
            if (fifo_in_ready) begin
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ### fabp_host_checker.sv
// Assertions on the flash bus controller pins.
module fabp_host_checker (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Status
  input wire req_ready,
  input wire device_ready_r,
  // Flash pins
  input wire chip_sel_n_r,
  input wire command_latch_en,
  input wire address_latch_en,
  input wire write_n_r,
  input wire read_n_r,
  input wire bus_low_lanes_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_excl; !(command_latch_en && address_latch_en); endproperty
  a_excl: assert property (p_excl) else $error("both latches high");
  property p_cmd; command_latch_en |-> !chip_sel_n_r && read_n_r; endproperty
  a_cmd: assert property (p_cmd) else $error("bad command cycle");
  property p_adr; address_latch_en |-> !chip_sel_n_r && read_n_r; endproperty
  a_adr: assert property (p_adr) else $error("bad address cycle");
  property p_wed; $rose(write_n_r) |-> !chip_sel_n_r && !bus_low_lanes_oe_n; endproperty
  a_wed: assert property (p_wed) else $error("write edge unselected");
  property p_wlo; $fell(write_n_r) |-> !write_n_r[*4] ##1 write_n_r; endproperty
  a_wlo: assert property (p_wlo) else $error("write pulse length");
  property p_rd;
    !read_n_r |-> write_n_r && bus_low_lanes_oe_n && !command_latch_en && !address_latch_en;
  endproperty
  a_rd: assert property (p_rd) else $error("bad read cycle");
  property p_rlo; $fell(read_n_r) |-> ##4 read_n_r; endproperty
  a_rlo: assert property (p_rlo) else $error("read pulse length");
  property p_qt; !device_ready_r |-> write_n_r && read_n_r && !req_ready; endproperty
  a_qt: assert property (p_qt) else $error("strobe in recovery");
endmodule

bind fabp_host fabp_host_checker u_chk (
  .clk(clk), .rst_n(rst_n), .req_ready(req_ready), .device_ready_r(device_ready_r),
  .chip_sel_n_r(chip_sel_n_r), .command_latch_en(command_latch_en),
  .address_latch_en(address_latch_en), .write_n_r(write_n_r), .read_n_r(read_n_r),
  .bus_low_lanes_oe_n(bus_low_lanes_oe_n));

// ### fabp_dev_model.sv
// Behavioural model of the flash device at its bus pins.
module fabp_dev_model #(
  parameter RECOV_NS = 160
) (
  // Control
  input  wire       chip_sel_n,
  input  wire       command_latch_en,
  input  wire       address_latch_en,
  input  wire       write_n,
  input  wire       read_n,
  input  wire       wp_n,
  input  wire       power_event,
  input  wire       make_busy,
  // Lanes
  input  wire [7:0] low_in,
  input  wire [7:0] high_in,
  output wire [7:0] low_out,
  output wire [7:0] high_out,
  output wire       ready_busy_od
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0]  last_cmd = 8'h00;
  reg [31:0] addr_q = 32'h0;
  reg [2:0]  addr_n = 3'h0;
  reg [15:0] last_wdata = 16'h0;
  reg        prot_reject = 1'b0;
  reg [7:0]  col = 8'h00;
  reg [15:0] word = 16'h0;
  reg        recov = 1'b0;
  wire       sel = !chip_sel_n && read_n;
  // Released lanes show the inverse of the last word.
  assign low_out = (!chip_sel_n && !read_n) ? word[7:0] : ~word[7:0];
  assign high_out = (!chip_sel_n && !read_n) ? word[15:8] : ~word[15:8];
  // Busy never looks at chip select, so a raised select cannot cut a read short.
  assign ready_busy_od = !(make_busy || recov);
  always @(posedge power_event) begin
    recov = 1'b1;
    #(RECOV_NS) recov = 1'b0;
  end
  // Other latch combinations are ignored.
  always @(posedge write_n) begin
    if (sel && command_latch_en && !address_latch_en) begin
      last_cmd = low_in;
      addr_n = 3'h0;
      col = 8'h00;
      if ((low_in == 8'h80 || low_in == 8'h60) && !wp_n) prot_reject = 1'b1;
    end else if (sel && address_latch_en && !command_latch_en) begin
      addr_q = {low_in, addr_q[31:8]};
      addr_n = addr_n + 3'h1;
    end else if (sel && !address_latch_en && !command_latch_en)
      last_wdata = {high_in, low_in};
  end
  always @(negedge read_n) begin
    if (!chip_sel_n && write_n && !command_latch_en && !address_latch_en) begin
      #6 word = {col, ~col};
      col = col + 8'h01;
    end
  end
endmodule

// ### fabp_host_tb.sv
// Self-checking bench for the flash bus port controller.
module fabp_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce = 1'b1, pev = 1'b0, rq_v = 1'b0, hold = 1'b0, we = 1'b0;
  logic rd_ready = 1'b0, mk_busy = 1'b0;
  logic [1:0] op = 2'h0;
  logic [15:0] d = 16'h0;
  wire req_ready, rd_valid, busy_r, dev_rdy, cs_n, cle, ale, w_n, r_n, wp_n, lo_oe, hi_oe, rb;
  wire [15:0] rd_data;
  wire [1:0] acnt;
  wire [7:0] lo_o, hi_o, lo_d, hi_d;
  wire [7:0] lo_w = !lo_oe ? lo_o : lo_d;
  wire [7:0] hi_w = !hi_oe ? hi_o : hi_d;
  int bad_count = 0, samples_checked = 0, cyc = 0, n, i;
  fabp_host #(.RECOVERY_CYC(20)) uut (.clk(clk), .rst_n(rst_n), .ce(ce), .power_event(pev),
    .req_valid(rq_v), .req_ready(req_ready), .req_op(op), .req_data(d),
    .req_hold_select(hold), .req_write_enable(we), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .busy_r(busy_r), .device_ready_r(dev_rdy), .addr_count_r(acnt),
    .chip_sel_n_r(cs_n), .command_latch_en(cle), .address_latch_en(ale), .write_n_r(w_n),
    .read_n_r(r_n), .wp_n_r(wp_n), .bus_low_lanes_i(lo_w), .bus_low_lanes_o(lo_o),
    .bus_low_lanes_oe_n(lo_oe), .bus_high_lanes_i(hi_w), .bus_high_lanes_o(hi_o),
    .bus_high_lanes_oe_n(hi_oe), .ready_busy_od(rb));
  fabp_dev_model #(.RECOV_NS(160)) u_dev (.chip_sel_n(cs_n), .command_latch_en(cle),
    .address_latch_en(ale), .write_n(w_n), .read_n(r_n), .wp_n(wp_n), .power_event(pev),
    .make_busy(mk_busy), .low_in(lo_w), .high_in(hi_w), .low_out(lo_d), .high_out(hi_d),
    .ready_busy_od(rb));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Holds the request until taken, then waits for the port to go idle, except after a read.
  task automatic send(input logic [1:0] o, input logic [15:0] v, input logic e);
    op = o;
    d = v;
    we = e;
    hold = (o == 2'h3);
    rq_v = 1'b1;
    for (n = 0; req_ready !== 1'b1 && n < 200; n++) step(1);
    chk(n < 200, 1);
    step(1);
    rq_v = 1'b0;
    step(1);
    for (n = 0; o != 2'h3 && req_ready !== 1'b1 && n < 200; n++) step(1);
    chk(n < 200, 1);
  endtask
  task automatic t_prog;
    send(2'h0, 16'hAB80, 1'b1);
    chk(u_dev.prot_reject, 0);
    send(2'h1, 16'h0011, 1'b1);
    send(2'h1, 16'h0022, 1'b1);
    send(2'h1, 16'h0033, 1'b1);
    chk(acnt, 3);
    send(2'h1, 16'h0001, 1'b1);
    chk(acnt, 0);
    send(2'h2, 16'hC0DE, 1'b1);
    chk(u_dev.last_cmd, 8'h80);
    chk(u_dev.addr_q, 32'h01332211);
    chk(u_dev.last_wdata, 16'hC0DE);
    send(2'h0, 16'h0060, 1'b0);
    chk(u_dev.prot_reject, 1);
    step(1);
    chk(cs_n, 1);
  endtask
  task automatic t_read;
    send(2'h0, 16'h0000, 1'b1);
    for (i = 0; i < 5; i++) send(2'h3, 16'h0, 1'b1);
    step(30);
    chk(u_dev.col, 4);
    rd_ready = 1'b1;
    for (i = 0; i < 5; i++) begin
      for (n = 0; rd_valid !== 1'b1 && n < 100; n++) step(1);
      chk(rd_data, {i[7:0], ~i[7:0]});
      step(1);
    end
    rd_ready = 1'b0;
    step(2);
    chk(rd_valid, 0);
    chk(cs_n, 0);
  endtask
  task automatic t_busy_power;
    mk_busy = 1'b1;
    step(5);
    chk(busy_r, 1);
    mk_busy = 1'b0;
    step(5);
    chk(busy_r, 0);
    pev = 1'b1;
    step(1);
    pev = 1'b0;
    step(3);
    chk({dev_rdy, req_ready}, 0);
    step(25);
    chk({dev_rdy, req_ready}, 3);
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    pev = 1'b1;
    step(3);
    rst_n = 1'b1;
    pev = 1'b0;
    step(15);
    chk({dev_rdy, req_ready}, 0);
    step(10);
    chk(req_ready, 1);
    t_prog();
    t_read();
    t_busy_power();
    conclude();
  end
endmodule
